// >>> timer_ch0_map.vh
// Register map, field positions, reset values and codes of timer channel 0.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TIMER_CH0_MAP_VH
`define TIMER_CH0_MAP_VH

// Register indexes; the byte address on the bus is four times the index
`define IDX_MODE 10'h062
`define IDX_CONTROL 10'h064
`define IDX_IO_CONTROL 10'h065
`define IDX_IRQ_ENABLE 10'h066
`define IDX_STATUS 10'h067
`define IDX_COUNT 10'h068
`define IDX_GEN_A 10'h06A
`define IDX_GEN_B 10'h06C

// Reset values; unused bits read as one
`define RST_MODE 8'h8F
`define RST_CONTROL 8'h80
`define RST_IO_CONTROL 8'h88
`define RST_IRQ_ENABLE 8'hF8
`define RST_STATUS 8'hF8
`define RST_COUNT 16'h0000
`define RST_GEN 16'hFFFF

// Writable bit masks
`define MASK_MODE 8'h70
`define MASK_CONTROL 8'h7F
`define MASK_IO_CONTROL 8'h77
`define MASK_FLAGS 8'h07

// Field positions
`define MODE_PHASE_BIT 6
`define MODE_PAIR_HI 5
`define MODE_PAIR_LO 4
`define CTL_CLEAR_HI 6
`define CTL_CLEAR_LO 5
`define CTL_EDGE_HI 4
`define CTL_EDGE_LO 3
`define CTL_PRESCALE_HI 2
`define CTL_PRESCALE_LO 0
`define IO_B_HI 6
`define IO_B_LO 4
`define IO_A_HI 2
`define IO_A_LO 0
`define FLAG_OVERFLOW 2
`define FLAG_MATCH_B 1
`define FLAG_MATCH_A 0

// Channel pair mode codes
`define PAIR_COMPLEMENTARY 2'b10
`define PAIR_RESET_SYNC 2'b11

// Counter clear source codes
`define CLEAR_NONE 2'b00
`define CLEAR_BY_A 2'b01
`define CLEAR_BY_B 2'b10
`define CLEAR_SYNC 2'b11

// External clock edge codes
`define EDGE_RISING 2'b00
`define EDGE_FALLING 2'b01

// General register I/O codes
`define IO_NONE 3'b000
`define IO_DRIVE_0 3'b001
`define IO_DRIVE_1 3'b010
`define IO_TOGGLE 3'b011
`define IO_CAP_RISE 3'b100
`define IO_CAP_FALL 3'b101
`define IO_CAP_BOTH 3'b110

`endif

// >>> clock_select.v
// Counter clock selection: internal prescaler taps and external clock pins.
// Assumes external clock pins are asynchronous to i_clk_sys and much slower.
`include "timer_ch0_map.vh"
`default_nettype none

module clock_select (
	input wire i_clk_sys,
	input wire i_reset,
	input wire [2:0] i_prescale_select,
	input wire [1:0] i_edge_select,
	input wire [3:0] i_ext_clock,
	output reg o_count_tick
);

	// ------------------------------------------------------------
	// Prescaler and pin synchronisers
	// ------------------------------------------------------------
	reg [2:0] divider;
	reg [3:0] ext_meta;
	reg [3:0] ext_sync;
	reg [3:0] ext_prev;
	reg [3:0] ext_rise;
	reg [3:0] ext_fall;
	reg next_tick;
	integer k;

	// Free-running divider; taps give 1/2, 1/4, 1/8 enables
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			divider <= 3'h0;
			ext_meta <= 4'h0;
			ext_sync <= 4'h0;
			ext_prev <= 4'h0;
		end else begin
			divider <= divider + 3'h1;
			ext_meta <= i_ext_clock;
			ext_sync <= ext_meta;
			ext_prev <= ext_sync;
		end
	end

	// Edge detection only on the second and third stages
	always @* begin
		for (k = 0; k < 4; k = k + 1) begin
			ext_rise[k] = ext_sync[k] & ~ext_prev[k];
			ext_fall[k] = ~ext_sync[k] & ext_prev[k];
		end
	end

	// ------------------------------------------------------------
	// Source multiplexer
	// ------------------------------------------------------------
	always @* begin
		next_tick = 1'b0;
		if (!i_prescale_select[2]) begin
			case (i_prescale_select[1:0])
				2'b00: next_tick = 1'b1;
				2'b01: next_tick = divider[0];
				2'b10: next_tick = &divider[1:0];
				default: next_tick = &divider;
			endcase
		end else begin
			// Edge select picks which pin transitions count
			case (i_edge_select)
				`EDGE_RISING: next_tick = ext_rise[i_prescale_select[1:0]];
				`EDGE_FALLING: next_tick = ext_fall[i_prescale_select[1:0]];
				default: next_tick = ext_rise[i_prescale_select[1:0]] |
					ext_fall[i_prescale_select[1:0]];
			endcase
		end
	end

	// Registered so the tick is a clean one-cycle enable
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_count_tick <= 1'b0;
		end else begin
			o_count_tick <= next_tick;
		end
	end

endmodule // clock_select
`default_nettype wire

// >>> compare_capture_unit.v
// One general register with output compare and input capture.
// Assumes the capture pin is asynchronous; count and tick are on i_clk_sys.
`include "timer_ch0_map.vh"
`default_nettype none

module compare_capture_unit #(
	parameter WIDTH = 16
) (
	input wire i_clk_sys,
	input wire i_reset,
	input wire [2:0] i_io_select,
	input wire [WIDTH-1:0] i_count,
	input wire i_count_tick,
	input wire i_capture_pin,
	input wire i_wr_en,
	input wire [WIDTH-1:0] i_wr_data,
	output reg [WIDTH-1:0] o_value,
	output wire o_match,
	output wire o_capture,
	output reg o_pin_out,
	output reg o_pin_oe
);

	// ------------------------------------------------------------
	// Capture pin synchroniser and edge select
	// ------------------------------------------------------------
	reg pin_meta;
	reg pin_sync;
	reg pin_prev;
	wire pin_rise;
	wire pin_fall;
	wire capture_mode;

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= i_capture_pin;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// Top bit of the select chooses capture over compare
	assign capture_mode = i_io_select[2];
	assign pin_rise = pin_sync & ~pin_prev;
	assign pin_fall = ~pin_sync & pin_prev;
	// Code 111 is undefined and captures nothing
	assign o_capture = capture_mode & (
		((i_io_select == `IO_CAP_RISE) & pin_rise) |
		((i_io_select == `IO_CAP_FALL) & pin_fall) |
		((i_io_select == `IO_CAP_BOTH) & (pin_rise | pin_fall)));
	// Match is judged on the count value being left at the tick
	assign o_match = ~capture_mode & i_count_tick & (i_count == o_value);

	// ------------------------------------------------------------
	// Register and compare output
	// ------------------------------------------------------------
	// Capture wins over a software write in the same cycle
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_value <= `RST_GEN;
		end else if (o_capture) begin
			o_value <= i_count;
		end else if (i_wr_en) begin
			o_value <= i_wr_data;
		end
	end

	// Pin is driven only in compare mode with an output code
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_pin_out <= 1'b0;
			o_pin_oe <= 1'b0;
		end else begin
			o_pin_oe <= ~capture_mode & (i_io_select != `IO_NONE);
			if (o_match) begin
				case (i_io_select)
					`IO_DRIVE_0: o_pin_out <= 1'b0;
					`IO_DRIVE_1: o_pin_out <= 1'b1;
					`IO_TOGGLE: o_pin_out <= ~o_pin_out;
					default: o_pin_out <= o_pin_out;
				endcase
			end
		end
	end

endmodule // compare_capture_unit
`default_nettype wire

// >>> timer_channel_control.v
// Timer channel 0: APB registers, counter, clear select, flags, interrupt.
// Assumes an APB master on i_clk_sys and asynchronous timer pins.
//
// Contract
// - Phase flag puts channel 2 into phase counting
// - Pair codes 00/01 keep channels 3,4 independent
// - Pair code 10 selects complementary PWM
// - Pair code 11 selects reset-synchronized PWM
// - Prescale codes 0-3 divide clock 1,2,4,8
// - Prescale codes 4-7 count external clocks A-D
// - Edge field picks rising, falling or both
// - Clear none, or on register A event
// - Clear code 10 clears on register B event
// - Clear code 11 clears with synchronized channels
// - Register A compare: none, 0, 1, toggle
// - Register A captures on rising/falling/both edges
// - Register B compare: none, 0, 1, toggle
// - Register B captures on rising/falling/both edges
// - Enables gate overflow, B and A interrupts
// - A flag on compare match or capture
// - Flags clear by read-one then write-zero
//
// Design decision made here: the APB interface to the registers.
`include "timer_ch0_map.vh"
`default_nettype none

module timer_channel_control #(
	parameter WIDTH = 16
) (
	input wire i_clk_sys,
	input wire i_reset,
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire [31:0] o_prdata,
	output wire o_pready,
	output wire o_pslverr,
	input wire [3:0] i_ext_clock,
	input wire i_capture_a,
	input wire i_capture_b,
	input wire i_sync_clear,
	output wire o_compare_a,
	output wire o_compare_a_oe,
	output wire o_compare_b,
	output wire o_compare_b_oe,
	output reg o_clear_event,
	output reg o_phase_count_mode,
	output reg o_pair_complementary,
	output reg o_pair_reset_sync,
	output wire o_reg_a_match_irq,
	output wire o_reg_b_match_irq,
	output wire o_overflow_irq,
	output wire o_irq
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	reg [7:0] mode_reg;
	reg [7:0] timer_control_0;
	reg [7:0] timer_io_control_0;
	reg [7:0] timer_irq_enable_0;
	reg [7:0] timer_status_0;
	reg [2:0] flag_armed;
	reg [WIDTH-1:0] timer_count;
	reg [31:0] read_data;
	reg read_hit;
	reg [7:0] next_status;
	reg [WIDTH-1:0] next_count;
	reg counter_clear;

	wire [WIDTH-1:0] general_reg_a;
	wire [WIDTH-1:0] general_reg_b;
	wire match_a;
	wire match_b;
	wire capture_a_evt;
	wire capture_b_evt;
	wire count_tick;
	wire overflow_evt;

	wire [9:0] reg_index;
	wire addr_aligned;
	wire access;
	wire wr;
	wire rd;
	wire wr_mode;
	wire wr_control;
	wire wr_io;
	wire wr_irq_enable;
	wire wr_status;
	wire wr_count;
	wire wr_gen_a;
	wire wr_gen_b;
	wire rd_status;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Zero wait states; the access phase completes in its first cycle
	assign reg_index = i_paddr[11:2];
	assign addr_aligned = (i_paddr[1:0] == 2'b00);
	assign access = i_psel & i_penable;
	assign wr = access & i_pwrite & read_hit;
	assign rd = access & ~i_pwrite & read_hit;
	assign o_pready = 1'b1;
	assign o_pslverr = access & ~read_hit;
	assign o_prdata = read_data;

	assign wr_mode = wr & (reg_index == `IDX_MODE);
	assign wr_control = wr & (reg_index == `IDX_CONTROL);
	assign wr_io = wr & (reg_index == `IDX_IO_CONTROL);
	assign wr_irq_enable = wr & (reg_index == `IDX_IRQ_ENABLE);
	assign wr_status = wr & (reg_index == `IDX_STATUS);
	assign wr_count = wr & (reg_index == `IDX_COUNT);
	assign wr_gen_a = wr & (reg_index == `IDX_GEN_A);
	assign wr_gen_b = wr & (reg_index == `IDX_GEN_B);
	assign rd_status = rd & (reg_index == `IDX_STATUS);

	// Read mux; narrow registers sit in the low bits, upper bits zero
	always @* begin
		read_hit = addr_aligned;
		read_data = 32'h0000_0000;
		case (reg_index)
			`IDX_MODE: read_data = {24'h000000, mode_reg};
			`IDX_CONTROL: read_data = {24'h000000, timer_control_0};
			`IDX_IO_CONTROL: read_data = {24'h000000, timer_io_control_0};
			`IDX_IRQ_ENABLE: read_data = {24'h000000, timer_irq_enable_0};
			`IDX_STATUS: read_data = {24'h000000, timer_status_0};
			`IDX_COUNT: read_data = {{(32-WIDTH){1'b0}}, timer_count};
			`IDX_GEN_A: read_data = {{(32-WIDTH){1'b0}}, general_reg_a};
			`IDX_GEN_B: read_data = {{(32-WIDTH){1'b0}}, general_reg_b};
			default: read_hit = 1'b0;
		endcase
		if (!addr_aligned) begin
			read_data = 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// Only the writable mask changes; the rest holds its reset ones
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			mode_reg <= `RST_MODE;
			timer_control_0 <= `RST_CONTROL;
			timer_io_control_0 <= `RST_IO_CONTROL;
			timer_irq_enable_0 <= `RST_IRQ_ENABLE;
		end else begin
			if (wr_mode) begin
				mode_reg <= (i_pwdata[7:0] & `MASK_MODE) | (`RST_MODE & ~`MASK_MODE);
			end
			if (wr_control) begin
				timer_control_0 <= (i_pwdata[7:0] & `MASK_CONTROL) |
					(`RST_CONTROL & ~`MASK_CONTROL);
			end
			if (wr_io) begin
				timer_io_control_0 <= (i_pwdata[7:0] & `MASK_IO_CONTROL) |
					(`RST_IO_CONTROL & ~`MASK_IO_CONTROL);
			end
			if (wr_irq_enable) begin
				timer_irq_enable_0 <= (i_pwdata[7:0] & `MASK_FLAGS) |
					(`RST_IRQ_ENABLE & ~`MASK_FLAGS);
			end
		end
	end

	// Mode indications for the other channels, registered
	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_phase_count_mode <= 1'b0;
			o_pair_complementary <= 1'b0;
			o_pair_reset_sync <= 1'b0;
		end else begin
			o_phase_count_mode <= mode_reg[`MODE_PHASE_BIT];
			// Codes 00 and 01 leave both indications low
			o_pair_complementary <= (mode_reg[`MODE_PAIR_HI:`MODE_PAIR_LO] ==
				`PAIR_COMPLEMENTARY);
			o_pair_reset_sync <= (mode_reg[`MODE_PAIR_HI:`MODE_PAIR_LO] ==
				`PAIR_RESET_SYNC);
		end
	end

	// ------------------------------------------------------------
	// Clock source and general registers
	// ------------------------------------------------------------
	clock_select u_clock_select (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_prescale_select(timer_control_0[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO]),
		.i_edge_select(timer_control_0[`CTL_EDGE_HI:`CTL_EDGE_LO]),
		.i_ext_clock(i_ext_clock),
		.o_count_tick(count_tick)
	);

	compare_capture_unit #(
		.WIDTH(WIDTH)
	) u_unit_a (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_io_select(timer_io_control_0[`IO_A_HI:`IO_A_LO]),
		.i_count(timer_count),
		.i_count_tick(count_tick),
		.i_capture_pin(i_capture_a),
		.i_wr_en(wr_gen_a),
		.i_wr_data(i_pwdata[WIDTH-1:0]),
		.o_value(general_reg_a),
		.o_match(match_a),
		.o_capture(capture_a_evt),
		.o_pin_out(o_compare_a),
		.o_pin_oe(o_compare_a_oe)
	);

	compare_capture_unit #(
		.WIDTH(WIDTH)
	) u_unit_b (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_io_select(timer_io_control_0[`IO_B_HI:`IO_B_LO]),
		.i_count(timer_count),
		.i_count_tick(count_tick),
		.i_capture_pin(i_capture_b),
		.i_wr_en(wr_gen_b),
		.i_wr_data(i_pwdata[WIDTH-1:0]),
		.o_value(general_reg_b),
		.o_match(match_b),
		.o_capture(capture_b_evt),
		.o_pin_out(o_compare_b),
		.o_pin_oe(o_compare_b_oe)
	);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// Wrap from all ones on a tick, unless a clear takes the same tick
	assign overflow_evt = count_tick & (&timer_count) & ~counter_clear;

	// Clear source selection
	always @* begin
		case (timer_control_0[`CTL_CLEAR_HI:`CTL_CLEAR_LO])
			`CLEAR_NONE: counter_clear = 1'b0;
			`CLEAR_BY_A: counter_clear = match_a | capture_a_evt;
			`CLEAR_BY_B: counter_clear = match_b | capture_b_evt;
			default: counter_clear = i_sync_clear;
		endcase
	end

	// Software write beats clear, clear beats counting
	always @* begin
		next_count = timer_count;
		if (wr_count) begin
			next_count = i_pwdata[WIDTH-1:0];
		end else if (counter_clear) begin
			next_count = {WIDTH{1'b0}};
		end else if (count_tick) begin
			next_count = timer_count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			timer_count <= `RST_COUNT;
			o_clear_event <= 1'b0;
		end else begin
			timer_count <= next_count;
			// Lets synchronized channels follow this channel's clear
			o_clear_event <= counter_clear & ~wr_count;
		end
	end

	// ------------------------------------------------------------
	// Status flags and interrupt
	// ------------------------------------------------------------
	// A flag clears only if read as one before the zero is written;
	// a new event in the clearing cycle keeps the flag set
	always @* begin
		next_status = timer_status_0;
		if (wr_status) begin
			next_status[2:0] = timer_status_0[2:0] & (i_pwdata[2:0] | ~flag_armed);
		end
		if (match_a | capture_a_evt) begin
			next_status[`FLAG_MATCH_A] = 1'b1;
		end
		if (match_b | capture_b_evt) begin
			next_status[`FLAG_MATCH_B] = 1'b1;
		end
		if (overflow_evt) begin
			next_status[`FLAG_OVERFLOW] = 1'b1;
		end
	end

	always @(posedge i_clk_sys) begin
		if (i_reset) begin
			timer_status_0 <= `RST_STATUS;
			flag_armed <= 3'h0;
		end else begin
			timer_status_0 <= next_status;
			if (rd_status) begin
				flag_armed <= timer_status_0[2:0];
			end else if (wr_status) begin
				flag_armed <= 3'h0;
			end
		end
	end

	// Per-source requests gated by their enables
	assign o_reg_a_match_irq = timer_status_0[`FLAG_MATCH_A] &
		timer_irq_enable_0[`FLAG_MATCH_A];
	assign o_reg_b_match_irq = timer_status_0[`FLAG_MATCH_B] &
		timer_irq_enable_0[`FLAG_MATCH_B];
	assign o_overflow_irq = timer_status_0[`FLAG_OVERFLOW] &
		timer_irq_enable_0[`FLAG_OVERFLOW];
	assign o_irq = o_reg_a_match_irq | o_reg_b_match_irq | o_overflow_irq;

endmodule // timer_channel_control
`default_nettype wire

// >>> timer_pins_model.sv
// Model of the timer pins: four external clocks and two capture inputs.
// Assumes a bench that calls its tasks; pins idle low between bursts.
`default_nettype none
module timer_pins_model (
	input wire logic i_clk_sys,
	output logic [3:0] o_ext_clock,
	output logic o_capture_a,
	output logic o_capture_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Pin levels at rest
	// ----------------------------------------
	initial begin
		o_ext_clock = 4'h0;
		o_capture_a = 1'b0;
		o_capture_b = 1'b0;
	end
	// Whole pulses, each level held six cycles so the synchronizer sees it
	task automatic ext_pulses(input int pin, input int n);
		repeat (n) begin
			@(posedge i_clk_sys);
			o_ext_clock[pin] <= 1'b1;
			repeat (6) @(posedge i_clk_sys);
			o_ext_clock[pin] <= 1'b0;
			repeat (6) @(posedge i_clk_sys);
		end
	endtask
	// Both capture pins move together, then settle for eight cycles
	task automatic set_capture(input logic v);
		@(posedge i_clk_sys);
		o_capture_a <= v;
		o_capture_b <= v;
		repeat (8) @(posedge i_clk_sys);
	endtask
endmodule // timer_pins_model
`default_nettype wire

// >>> timer_channel_props.sv
// Checker of the channel port behaviour, bound to the top module.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module timer_channel_props (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_compare_a_oe,
	input wire logic o_pair_complementary,
	input wire logic o_pair_reset_sync,
	input wire logic o_reg_a_match_irq,
	input wire logic o_reg_b_match_irq,
	input wire logic o_overflow_irq,
	input wire logic o_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	// ----------------------------------------
	// Write history, so a drop can be traced to software
	// ----------------------------------------
	logic wr_q;
	logic wr_q2;
	always @(posedge i_clk_sys) begin
		wr_q <= i_reset ? 1'b0 : (i_psel && i_penable && i_pwrite);
		wr_q2 <= i_reset ? 1'b0 : wr_q;
	end
	sequence s_access;
		i_psel && i_penable;
	endsequence
	sequence s_bad_addr;
		s_access ##0 (i_paddr[1:0] != 2'b00);
	endsequence
	property p_ready; s_access |-> o_pready; endproperty
	property p_err_idle; !(i_psel && i_penable) |-> !o_pslverr; endproperty
	property p_unaligned; s_bad_addr |-> o_pslverr && o_prdata == 32'h0; endproperty
	property p_ctl_unused; i_psel && i_paddr == 12'h190 |-> o_prdata[31:7] == 25'h1; endproperty
	property p_stat_unused; i_psel && i_paddr == 12'h19C |-> o_prdata[7:3] == 5'h1F; endproperty
	property p_pair_excl; !(o_pair_complementary && o_pair_reset_sync); endproperty
	property p_irq_or;
		o_irq == (o_reg_a_match_irq || o_reg_b_match_irq || o_overflow_irq);
	endproperty
	property p_irq_fall;
		$fell(o_reg_a_match_irq) || $fell(o_reg_b_match_irq) || $fell(o_overflow_irq) |-> wr_q;
	endproperty
	property p_oe_cause; $changed(o_compare_a_oe) |-> wr_q || wr_q2; endproperty
	a_ready: assert property (p_ready) else $error("pready low in access");
	a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
	a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
	a_ctl_unused: assert property (p_ctl_unused) else $error("control unused bits");
	a_stat_unused: assert property (p_stat_unused) else $error("status unused bits");
	a_pair_excl: assert property (p_pair_excl) else $error("both pair modes on");
	a_irq_or: assert property (p_irq_or) else $error("irq not the OR of sources");
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
	a_oe_cause: assert property (p_oe_cause) else $error("compare enable moved alone");
endmodule // timer_channel_props
bind timer_channel_control timer_channel_props u_props (.i_clk_sys(i_clk_sys),
	.i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_compare_a_oe(o_compare_a_oe), .o_pair_complementary(o_pair_complementary),
	.o_pair_reset_sync(o_pair_reset_sync), .o_reg_a_match_irq(o_reg_a_match_irq),
	.o_reg_b_match_irq(o_reg_b_match_irq), .o_overflow_irq(o_overflow_irq), .o_irq(o_irq));
`default_nettype wire

// >>> timer_channel_control_test.sv
// Self-checking bench of timer channel 0 over APB.
// Assumes the map header, pin model and checker are compiled first.
`include "timer_ch0_map.vh"
`default_nettype none
module timer_channel_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A_MODE = 12'h188;
	localparam logic [11:0] A_CTL = 12'h190;
	localparam logic [11:0] A_IO = 12'h194;
	localparam logic [11:0] A_IEN = 12'h198;
	localparam logic [11:0] A_STAT = 12'h19C;
	localparam logic [11:0] A_CNT = 12'h1A0;
	localparam logic [11:0] A_GA = 12'h1A8;
	localparam logic [11:0] A_GB = 12'h1B0;
	logic clk, rst, psel, penable, pwrite, sync_clr, pready, pslverr, rerr, cap_a, cap_b;
	logic cmp_a, cmp_a_oe, phase, pair_c, pair_r, irq_a, irq_ov, irq;
	logic cmp_b, cmp_b_oe, irq_b, clr_evt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [3:0] ext;
	int err_total, samples_checked;
	timer_pins_model u_pins (.i_clk_sys(clk), .o_ext_clock(ext), .o_capture_a(cap_a),
		.o_capture_b(cap_b));
	timer_channel_control u_dut (.i_clk_sys(clk), .i_reset(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_ext_clock(ext),
		.i_capture_a(cap_a), .i_capture_b(cap_b), .i_sync_clear(sync_clr),
		.o_compare_a(cmp_a), .o_compare_a_oe(cmp_a_oe), .o_compare_b(cmp_b),
		.o_compare_b_oe(cmp_b_oe),
		.o_clear_event(clr_evt), .o_phase_count_mode(phase), .o_pair_complementary(pair_c),
		.o_pair_reset_sync(pair_r), .o_reg_a_match_irq(irq_a), .o_reg_b_match_irq(irq_b),
		.o_overflow_irq(irq_ov), .o_irq(irq));
	// ----------------------------------------
	// Clock and shared helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; read data taken at the edge that sees pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Only the watchdog ends a wait for the answer
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_map;
		logic [11:0] a[5] = '{A_MODE, A_CTL, A_IO, A_IEN, A_STAT};
		logic [7:0] v[5] = '{`RST_MODE, `RST_CONTROL, `RST_IO_CONTROL, `RST_IRQ_ENABLE, `RST_STATUS};
		for (int i = 0; i < 5; i++) begin
			rd(a[i]);
			chk(rdata, {24'h0, v[i]});
		end
		wr(A_IEN, 32'hFF);
		rd(A_IEN);
		chk(rdata, 32'hFF);
		rd(12'h1FC);
		chk(rdata, 32'h0);
		chk(rerr, 1'b1);
		wr(12'h191, 32'h7F);
		chk(rerr, 1'b1);
		// A refused write must leave the control register alone
		rd(A_CTL);
		chk(rdata, {24'h0, `RST_CONTROL});
		wr(A_IEN, 32'h0);
	endtask
	// Compare codes on A and B, clear on A match, then flags and masking
	task automatic t_compare;
		logic p, pb;
		wr(A_GA, 32'h5);
		wr(A_GB, 32'h3);
		wr(A_CTL, 32'h20);
		// Free-running count is far past 5; restart it inside the period
		wr(A_CNT, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(A_IO, (c << 4) | c);
			repeat (20) @(negedge clk);
			chk({cmp_a_oe, cmp_b_oe}, {2{c != 0}});
			if (c == 1 || c == 2) chk({cmp_a, cmp_b}, {2{c == 2}});
		end
		p = cmp_a;
		pb = cmp_b;
		repeat (6) @(negedge clk);
		chk({cmp_a, cmp_b}, {!p, !pb});
		wr(A_IEN, 32'h3);
		repeat (2) @(negedge clk);
		chk({irq, irq_a, irq_b}, 3'b111);
		wr(A_IEN, 32'h0);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		wr(A_IEN, 32'h3);
		wr(A_CTL, 32'h24);
		wr(A_STAT, 32'hFF);
		rd(A_STAT);
		chk(rdata, 32'hFB);
		wr(A_STAT, 32'hF8);
		repeat (2) @(negedge clk);
		chk(irq, 1'b0);
		wr(A_CNT, 32'hFFFD);
		wr(A_IEN, 32'h4);
		wr(A_CTL, 32'h0);
		repeat (10) @(negedge clk);
		chk(irq_ov, 1'b1);
		wr(A_IEN, 32'h0);
	endtask
	// Internal division: span between two count reads is 67 cycles
	task automatic t_prescale;
		logic [15:0] q0, d;
		for (int c = 0; c < 4; c++) begin
			wr(A_CTL, c);
			rd(A_CNT);
			q0 = rdata[15:0];
			repeat (64) @(posedge clk);
			rd(A_CNT);
			d = rdata[15:0] - q0;
			chk(d >= (67 >> c) && d <= (67 >> c) + 1, 1'b1);
		end
	endtask
	// Each external pin with an edge code; three whole pulses each
	task automatic t_ext_clock;
		logic [1:0] e;
		for (int i = 0; i < 4; i++) begin
			e = (i == 3) ? 2'b00 : i[1:0];
			wr(A_CTL, {27'h0, e, 3'h4 + i[2:0]});
			wr(A_CNT, 32'h0);
			u_pins.ext_pulses(i, 3);
			repeat (8) @(posedge clk);
			rd(A_CNT);
			chk(rdata, e[1] ? 32'h6 : 32'h3);
		end
	endtask
	// Capture codes on both registers, count cleared by B capture
	task automatic t_capture;
		logic [31:0] v, x;
		logic hit;
		wr(A_CTL, 32'h44);
		for (int c = 4; c < 7; c++) begin
			wr(A_IO, (c << 4) | c);
			wr(A_GA, 32'h0);
			wr(A_GB, 32'h0);
			x = 32'h0;
			for (int lv = 1; lv >= 0; lv--) begin
				v = (lv == 1) ? 32'h100 + c : 32'h200 + c;
				hit = (lv == 1) ? (c != 5) : (c != 4);
				x = hit ? v : x;
				wr(A_CNT, v);
				u_pins.set_capture(lv[0]);
				rd(A_GB);
				chk(rdata, x);
				rd(A_GA);
				chk(rdata, x);
				rd(A_CNT);
				chk(rdata, hit ? 32'h0 : v);
			end
		end
	endtask
	// Mode indications and synchronous clear
	task automatic t_modes;
		for (int m = 0; m < 4; m++) begin
			wr(A_MODE, (m << 4) | ((m & 1) << 6));
			repeat (2) @(negedge clk);
			chk({pair_c, pair_r}, {m == 2, m == 3});
			chk(phase, m[0]);
		end
		wr(A_CTL, 32'h64);
		wr(A_CNT, 32'h55);
		sync_clr <= 1'b1;
		@(posedge clk);
		sync_clr <= 1'b0;
		// Clear indication stands for the cycle after the clear
		@(negedge clk);
		chk(clr_evt, 1'b1);
		repeat (3) @(posedge clk);
		rd(A_CNT);
		chk(rdata, 32'h0);
	endtask
	// ----------------------------------------
	// Verdict, watchdog and main sequence
	// ----------------------------------------
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		err_total++;
		test_done;
	end
	initial begin
		{rst, psel, penable, pwrite, sync_clr} = 5'h10;
		paddr = 12'h0;
		pwdata = 32'h0;
		err_total = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset_map();
		t_compare();
		t_prescale();
		t_ext_clock();
		t_capture();
		t_modes();
		test_done;
	end
endmodule // timer_channel_control_test
`default_nettype wire
